// ### verilog/blse_pkg.sv
// shared constants and types for the line and span engine
package blse_pkg;
  // device register byte addresses on the link
  localparam logic [31:0] REG_STEP_ONE   = 32'h0000_0000;
  localparam logic [31:0] REG_STEP_TWO   = 32'h0000_0004;
  localparam logic [31:0] REG_INIT_LEN   = 32'h0000_0008;
  localparam logic [31:0] REG_ROP        = 32'h0000_000C;
  localparam logic [31:0] REG_FG         = 32'h0000_0010;
  localparam logic [31:0] REG_BG         = 32'h0000_0014;
  localparam logic [31:0] REG_MODE       = 32'h0000_0018;
  localparam logic [31:0] REG_INTERLOCK  = 32'h0000_001C;
  localparam logic [31:0] REG_DITHER_COL = 32'h0000_0020;
  localparam logic [31:0] REG_DITHER_ROW = 32'h0000_0024;
  localparam logic [31:0] REG_DEST_HOLD  = 32'h0000_0028;
  localparam logic [31:0] REG_SPAN_CTL   = 32'h0000_002C;
  // field positions
  localparam int INC_HI     = 31;
  localparam int INC_LO     = 16;
  localparam int EINC_HI    = 15;
  localparam int ERR_HI     = 31;
  localparam int ERR_LO     = 16;
  localparam int LEN_HI     = 3;
  localparam int WD_LSB_HI  = 17;
  localparam int WD_LSB_LO  = 16;
  localparam int WD_MASK_HI = 15;
  localparam int ROP_HI     = 3;
  localparam int BMP_HI     = 10;
  localparam int BMP_LO     = 8;
  localparam int BMASK_HI   = 19;
  localparam int BMASK_LO   = 16;
  // engine_mode_control fields
  localparam logic [1:0] MODE_SIMPLE = 2'h0;
  localparam logic [1:0] MODE_LINE   = 2'h1;
  localparam logic [1:0] MODE_SCALE  = 2'h2;
  localparam int MODE_PACKED  = 4;
  localparam int MODE_REDUCE  = 5;
  localparam int MODE_HOLDER  = 6;
  localparam int MODE_CONT    = 7;
  // span control fields: start pixel, end pixel, trailing draw count
  localparam int SPAN_START_LO = 0;
  localparam int SPAN_END_LO   = 4;
  localparam int SPAN_DRAW_LO  = 8;
  localparam int PIX_BITS      = 8;
  localparam logic [1:0]  LAST_PIX    = 2'h3;
  localparam logic [31:0] STEP_PACKED = 32'h0000_0001;
  localparam logic [31:0] STEP_DWORD  = 32'h0000_0004;
  localparam logic [3:0]  LEN_ONE     = 4'h1;
  // host controller registers on AXI4-Lite
  localparam logic [3:0] HREG_ADDR   = 4'h0;
  localparam logic [3:0] HREG_DATA   = 4'h4;
  localparam logic [3:0] HREG_CTRL   = 4'h8;
  localparam logic [3:0] HREG_STATUS = 4'hC;
  localparam int HST_PENDING = 0;
  localparam int HST_OVERRUN = 1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_LINE, ST_FETCH, ST_SCALE, ST_TRAIL} blse_state_t;
endpackage : blse_pkg

// ### verilog/blse_link_if.sv
// command link between host controller and engine
`timescale 1ns/100ps
`default_nettype none
interface blse_link_if;
  logic        cmdValid;
  logic        cmdReady;
  logic        cmdToFrame;
  logic [31:0] cmdAddr;
  logic [31:0] cmdData;
  modport host (output cmdValid, output cmdToFrame, output cmdAddr, output cmdData,
                input cmdReady);
  modport dev  (input cmdValid, input cmdToFrame, input cmdAddr, input cmdData,
                output cmdReady);
endinterface : blse_link_if
`default_nettype wire

// ### verilog/blse_device.sv
// line and scaled span engine: registers, stepping and pixel output
// Behaviour
// RL1 - frame write in line mode draws segment
// RL2 - write data: address bits 17:16, mask 15:0
// RL3 - packed 8bpp uses data address bits
// RL4 - current address loaded before stepping
// RL5 - mask one foreground, zero background
// RL6 - each pixel carries rop, bitmap, byte mask
// RL7 - negative error: add increments one
// RL8 - nonnegative error: increment two, subtract error
// RL9 - decrement length, stop at zero
// RL10 - track target byte within dword
// RL11 - host loads stepping terms before drawing
// RL12 - span start: write, holder, or continuation
// RL13 - skip source pixels before start pixel
// RL14 - initial error sets first pixel repeats
// RL15 - ignore pixels after end pixel
// RL16 - trailing count repeats last source pixel
// RL17 - bad start/end never hangs engine
// RL18 - interlocked register updates stall during copy
// RL19 - host writes interlock before register updates
// RL20 - host presets error for occluded spans
// RL21 - host keeps parent span increments
// RL22 - new frame write waits for segment
`timescale 1ns/100ps
`default_nettype none
module blse_device
  import blse_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  blse_link_if.dev         link,
  input  wire logic        srcValid,
  input  wire logic [31:0] srcData,
  input  wire logic        srcLast,
  output logic             srcReady,
  output logic             pixValid,
  input  wire logic        pixReady,
  output logic [31:0]      pixAddr,
  output logic [31:0]      pixData,
  output logic [3:0]       pixByteMask,
  output logic [3:0]       pixRop,
  output logic [2:0]       pixBitmap,
  output logic             busy
);
  import blse_pkg::*;

  typedef struct packed {
    blse_state_t  state;
    logic [31:0]  stepOne;
    logic [31:0]  stepTwo;
    logic [31:0]  initLen;
    logic [31:0]  rop;
    logic [31:0]  fg;
    logic [31:0]  bg;
    logic [31:0]  mode;
    logic [31:0] ditherCol;
    logic [31:0] ditherRow;
    logic [31:0] destHold;
    logic [31:0] spanCtl;
    logic         armed;
    logic [31:0]  addr;
    logic [15:0]  err;
    logic [3:0]   len;
    logic [15:0]  mask;
    logic [31:0]  dword;
    logic         lastDword;
    logic [1:0]   pixIdx;
    logic [3:0]   trail;
    logic [31:0]  spanEnd;
    logic         pixValid;
    logic [31:0]  pixAddr;
    logic [31:0]  pixData;
  } blse_dev_t;

  blse_dev_t s;
  blse_dev_t next_s;

  // sign-extended address increment from the upper half of a stepping register
  function automatic logic [31:0] addrInc(input logic [31:0] r);
    addrInc = {{16{r[INC_HI]}}, r[INC_HI:INC_LO]};
  endfunction : addrInc

  function automatic logic isInterlocked(input logic [31:0] a);
    isInterlocked = (a == REG_STEP_ONE) || (a == REG_STEP_TWO) || (a == REG_INIT_LEN) ||
                    (a == REG_DITHER_COL) || (a == REG_DITHER_ROW);
  endfunction : isInterlocked

  logic        copyBusy;
  logic        regStall;
  logic        frameStall;
  logic        packed8;
  logic [31:0] pixStep;
  logic [1:0]  startPix;
  logic [1:0]  endPix;
  logic [7:0]  curPix;
  logic        engineFree;

  always_comb
  begin
    copyBusy   = (s.state == ST_FETCH) || (s.state == ST_SCALE) || (s.state == ST_TRAIL);
    packed8    = s.mode[MODE_PACKED];
    pixStep    = packed8 ? STEP_PACKED : STEP_DWORD;
    startPix   = s.spanCtl[SPAN_START_LO +: 2];
    endPix     = s.spanCtl[SPAN_END_LO +: 2];
    curPix     = s.dword[s.pixIdx * PIX_BITS +: PIX_BITS];
    engineFree = !s.pixValid;
    regStall   = s.armed && copyBusy && isInterlocked(link.cmdAddr); // [RL18]
    frameStall = (s.state != ST_IDLE) || s.pixValid; // [RL22]
    link.cmdReady = link.cmdToFrame ? !frameStall : !regStall;
    srcReady   = (s.state == ST_FETCH);
  end

  always_comb
  begin
    next_s = s;
    if (s.pixValid && pixReady)
    begin
      next_s.pixValid = 1'b0;
    end
    if (s.armed && !copyBusy)
    begin
      next_s.armed = 1'b0;
    end
    if (link.cmdValid && link.cmdReady && !link.cmdToFrame)
    begin
      case (link.cmdAddr)
        REG_STEP_ONE:   next_s.stepOne   = link.cmdData;
        REG_STEP_TWO:   next_s.stepTwo   = link.cmdData;
        REG_INIT_LEN:   next_s.initLen   = link.cmdData;
        REG_ROP:        next_s.rop       = link.cmdData;
        REG_FG:         next_s.fg        = link.cmdData;
        REG_BG:         next_s.bg        = link.cmdData;
        REG_MODE:       next_s.mode      = link.cmdData;
        REG_INTERLOCK:  next_s.armed     = 1'b1;
        REG_DITHER_COL: next_s.ditherCol = link.cmdData;
        REG_DITHER_ROW: next_s.ditherRow = link.cmdData;
        REG_DEST_HOLD:  next_s.destHold  = link.cmdData;
        REG_SPAN_CTL:   next_s.spanCtl   = link.cmdData;
        default:        next_s.armed     = s.armed;
      endcase
    end
    case (s.state)
      ST_IDLE:
      begin
        if (link.cmdValid && link.cmdReady && link.cmdToFrame)
        begin
          next_s.err = s.initLen[ERR_HI:ERR_LO];
          if (s.mode[1:0] == MODE_LINE)
          begin
            next_s.state = ST_LINE; // [RL1]
            next_s.addr  = packed8 ? {link.cmdAddr[31:2], link.cmdData[WD_LSB_HI:WD_LSB_LO]}
                                   : {link.cmdAddr[31:2], 2'h0}; // [RL3] [RL4] [RL2]
            next_s.mask  = link.cmdData[WD_MASK_HI:0]; // [RL2]
            next_s.len   = s.initLen[LEN_HI:0];
          end
          else if (s.mode[1:0] == MODE_SCALE)
          begin
            next_s.state  = ST_FETCH;
            next_s.pixIdx = startPix; // [RL13]
            if (s.mode[MODE_CONT])
            begin
              next_s.addr = s.spanEnd + addrInc(s.stepOne); // [RL12]
            end
            else if (s.mode[MODE_HOLDER])
            begin
              next_s.addr = s.destHold; // [RL12]
            end
            else
            begin
              next_s.addr = link.cmdAddr; // [RL12]
            end
          end
        end
      end
      ST_LINE:
      begin
        if (engineFree)
        begin
          next_s.pixValid = 1'b1;
          next_s.pixAddr  = s.addr; // [RL10]
          next_s.pixData  = s.mask[0] ? s.fg : s.bg; // [RL5]
          next_s.mask     = {1'b0, s.mask[WD_MASK_HI:1]};
          if (s.err[15])
          begin
            next_s.addr = s.addr + addrInc(s.stepOne); // [RL7]
            next_s.err  = s.err + s.stepOne[EINC_HI:0]; // [RL7]
          end
          else
          begin
            next_s.addr = s.addr + addrInc(s.stepTwo); // [RL8]
            next_s.err  = s.err - s.stepTwo[EINC_HI:0]; // [RL8]
          end
          next_s.len = s.len - LEN_ONE; // [RL9]
          if (s.len == LEN_ONE)
          begin
            next_s.state = ST_IDLE; // [RL9]
          end
        end
      end
      ST_FETCH:
      begin
        if (srcValid)
        begin
          next_s.dword     = srcData;
          next_s.lastDword = srcLast;
          next_s.state     = ST_SCALE;
        end
      end
      ST_SCALE:
      begin
        if (s.lastDword && (s.pixIdx > endPix))
        begin
          next_s.state   = ST_IDLE; // [RL17]
          next_s.spanEnd = s.addr;
        end
        else if (s.lastDword && (s.pixIdx == endPix))
        begin
          next_s.state = ST_TRAIL; // [RL15]
          next_s.trail = s.spanCtl[SPAN_DRAW_LO +: 4]; // [RL16]
        end
        else if (s.err[15])
        begin
          next_s.err = s.err + s.stepOne[EINC_HI:0]; // [RL14]
          if (s.pixIdx == LAST_PIX)
          begin
            next_s.pixIdx = 2'h0;
            next_s.state  = ST_FETCH;
          end
          else
          begin
            next_s.pixIdx = s.pixIdx + 2'h1;
          end
        end
        else if (engineFree)
        begin
          next_s.pixValid = 1'b1;
          next_s.pixAddr  = s.addr;
          next_s.pixData  = {24'h00_0000, curPix};
          next_s.addr     = s.addr + pixStep;
          next_s.err      = s.err - s.stepTwo[EINC_HI:0]; // [RL14]
          if (s.mode[MODE_REDUCE])
          begin
            if (s.pixIdx == LAST_PIX)
            begin
              next_s.pixIdx = 2'h0;
              next_s.state  = ST_FETCH;
            end
            else
            begin
              next_s.pixIdx = s.pixIdx + 2'h1;
            end
          end
        end
      end
      ST_TRAIL:
      begin
        if (s.trail == 4'h0)
        begin
          next_s.state   = ST_IDLE;
          next_s.spanEnd = s.addr;
        end
        else if (engineFree)
        begin
          next_s.pixValid = 1'b1; // [RL16]
          next_s.pixAddr  = s.addr;
          next_s.pixData  = {24'h00_0000, curPix};
          next_s.addr     = s.addr + pixStep;
          next_s.trail    = s.trail - 4'h1;
        end
      end
      default:
      begin
        next_s.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign pixValid    = s.pixValid;
  assign pixAddr     = s.pixAddr;
  assign pixData     = s.pixData;
  assign pixByteMask = s.rop[BMASK_HI:BMASK_LO]; // [RL6]
  assign pixRop      = s.rop[ROP_HI:0]; // [RL6]
  assign pixBitmap   = s.rop[BMP_HI:BMP_LO]; // [RL6]
  assign busy        = (s.state != ST_IDLE) || s.pixValid;
endmodule : blse_device
`default_nettype wire

// ### verilog/blse_host.sv
// host controller: AXI4-Lite command registers driving the engine link
`timescale 1ns/100ps
`default_nettype none
module blse_host
  import blse_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  blse_link_if.host        link,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import blse_pkg::*;

  typedef struct packed {
    logic [31:0] cmdAddr;
    logic [31:0] cmdData;
    logic        toFrame;
    logic        pending;
    logic        overrun;
    logic [7:0]  doneCnt;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } blse_host_t;

  blse_host_t s;
  blse_host_t next_s;
  logic       wrTake;
  logic       sent;

  always_comb
  begin
    wrTake        = s_axi_awvalid && s_axi_wvalid && !s.bvalid;
    s_axi_awready = wrTake;
    s_axi_wready  = wrTake;
    s_axi_arready = !s.rvalid;
    sent          = s.pending && link.cmdReady; // [RL19]
    next_s        = s;
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (sent)
    begin
      next_s.pending = 1'b0;
      next_s.doneCnt = s.doneCnt + 8'h01;
    end
    if (wrTake)
    begin
      next_s.bvalid = 1'b1;
      next_s.bresp  = RESP_OKAY;
      case (s_axi_awaddr)
        HREG_ADDR: next_s.cmdAddr = s_axi_wdata;
        HREG_DATA: next_s.cmdData = s_axi_wdata; // [RL11] [RL20] [RL21]
        HREG_CTRL:
        begin
          if (s.pending && !sent)
          begin
            next_s.overrun = 1'b1;
          end
          else
          begin
            next_s.toFrame = s_axi_wdata[0];
            next_s.pending = 1'b1;
          end
        end
        HREG_STATUS:
        begin
          if (s_axi_wdata[HST_OVERRUN] && !(s.pending && !sent && s_axi_awaddr == HREG_CTRL))
          begin
            next_s.overrun = 1'b0;
          end
        end
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && !s.rvalid)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      case (s_axi_araddr)
        HREG_ADDR:   next_s.rdata = s.cmdAddr;
        HREG_DATA:   next_s.rdata = s.cmdData;
        HREG_CTRL:   next_s.rdata = {31'h0000_0000, s.toFrame};
        HREG_STATUS: next_s.rdata = {16'h0000, s.doneCnt, 6'h00, s.overrun, s.pending};
        default:
        begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign link.cmdValid   = s.pending;
  assign link.cmdToFrame = s.toFrame;
  assign link.cmdAddr    = s.cmdAddr;
  assign link.cmdData    = s.cmdData;
  assign s_axi_bvalid    = s.bvalid;
  assign s_axi_bresp     = s.bresp;
  assign s_axi_rvalid    = s.rvalid;
  assign s_axi_rresp     = s.rresp;
  assign s_axi_rdata     = s.rdata;
endmodule : blse_host
`default_nettype wire

// ### test/blse_checker.sv
// link and pixel output assertions for the host and engine pair
`timescale 1ns/100ps
`default_nettype none
module blse_checker (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        cmdValid,
  input wire logic        cmdReady,
  input wire logic        cmdToFrame,
  input wire logic [31:0] cmdAddr,
  input wire logic [31:0] cmdData,
  input wire logic        pixValid,
  input wire logic        pixReady,
  input wire logic [31:0] pixAddr,
  input wire logic [31:0] pixData,
  input wire logic [3:0]  pixByteMask,
  input wire logic [3:0]  pixRop,
  input wire logic [2:0]  pixBitmap,
  input wire logic        busy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_pix_held: assert property (pixValid && !pixReady |=> pixValid && $stable(pixAddr)
    && $stable(pixData)) else $error("pixel offer dropped or changed before acceptance");
  a_attr_held: assert property (pixValid && !pixReady |=> $stable(pixRop)
    && $stable(pixBitmap) && $stable(pixByteMask)) else $error("pixel attributes changed");
  a_pix_gap: assert property (pixValid && pixReady |=> !pixValid)
    else $error("pixel offered right after acceptance");
  a_frame_refused: assert property (cmdValid && cmdToFrame && busy |-> !cmdReady)
    else $error("frame write taken while engine busy");
  a_busy_pix: assert property (pixValid |-> busy)
    else $error("pixel pending while not busy");
  a_ready_idle: assert property (!busy |-> cmdReady)
    else $error("idle engine refused a command");
  a_cmd_hold: assert property (cmdValid && !cmdReady |=> cmdValid && $stable(cmdAddr)
    && $stable(cmdData) && $stable(cmdToFrame)) else $error("command changed before taken");
  a_cmd_once: assert property (cmdValid && cmdReady |=> !cmdValid)
    else $error("command offered twice");
  a_busy_bound: assert property ($rose(busy) |-> ##[1:600] !busy)
    else $error("engine stayed busy too long");
endmodule : blse_checker
`default_nettype wire

// ### test/bresenham_line_and_span_engine_bench.sv
// self-checking bench: host controller drives the engine through lines and scaled spans
`timescale 1ns/100ps
`default_nettype none
module bresenham_line_and_span_engine_bench;
  import blse_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  awaddr = 4'h0;
  logic [3:0]  araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        pixReady = 1'b0;
  logic        srcValid = 1'b0;
  logic        srcLast = 1'b0;
  logic [31:0] srcData = 32'h0;
  logic [32:0] srcq[$];
  logic        awready, wready, bvalid, arready, rvalid, srcReady, pixValid, busy;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, pixAddr, pixData, fg, bg, rop;
  logic [3:0]  pixByteMask, pixRop, len;
  logic [2:0]  pixBitmap;
  logic [15:0] inc1, inc2, einc1, einc2, ierr;
  logic [74:0] expq[$];
  int          errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  blse_link_if link();
  blse_host u_blse_host (.core_clk(core_clk), .rst(rst), .link(link), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  blse_device u_blse_device (.core_clk(core_clk), .rst(rst), .link(link), .srcValid(srcValid),
    .srcData(srcData), .srcLast(srcLast), .srcReady(srcReady), .pixValid(pixValid),
    .pixReady(pixReady), .pixAddr(pixAddr), .pixData(pixData), .pixByteMask(pixByteMask),
    .pixRop(pixRop), .pixBitmap(pixBitmap), .busy(busy));
  blse_checker u_blse_checker (.core_clk(core_clk), .rst(rst), .cmdValid(link.cmdValid),
    .cmdReady(link.cmdReady), .cmdToFrame(link.cmdToFrame), .cmdAddr(link.cmdAddr),
    .cmdData(link.cmdData), .pixValid(pixValid), .pixReady(pixReady), .pixAddr(pixAddr),
    .pixData(pixData), .pixByteMask(pixByteMask), .pixRop(pixRop), .pixBitmap(pixBitmap),
    .busy(busy));

  always #5 core_clk = ~core_clk;

  task automatic fail(input string m);
    errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : fail

  task automatic tally_and_finish();
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge core_clk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge core_clk); while (bvalid !== 1'b1);
    n_checks++;
    if (bresp !== RESP_OKAY) fail("write response");
    bready <= 1'b0;
    @(posedge core_clk);
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    d = rdata;
    n_checks++;
    if (rresp !== RESP_OKAY) fail("read response");
    rready <= 1'b0;
    @(posedge core_clk);
  endtask : axi_read

  task automatic send(input logic toF, input logic [31:0] a, input logic [31:0] d);
    logic [31:0] st;
    axi_write(HREG_ADDR, a);
    axi_write(HREG_DATA, d);
    axi_write(HREG_CTRL, {31'h0, toF});
    do axi_read(HREG_STATUS, st); while (st[HST_PENDING] !== 1'b0);
  endtask : send

  // queue the pixels one segment should produce
  task automatic expect_seg(input logic [31:0] a, input logic [31:0] d, input logic pk);
    logic [31:0]        ad;
    logic signed [15:0] er;
    int                 n;
    ad = pk ? {a[31:2], d[17:16]} : {a[31:2], 2'b00};
    er = ierr;
    n = (len == 4'h0) ? 16 : int'(len);
    for (int i = 0; i < n; i++)
    begin
      expq.push_back({ad, d[i] ? fg : bg, rop[3:0], rop[10:8], rop[19:16]});
      if (er < 0)
      begin
        ad = ad + {{16{inc1[15]}}, inc1};
        er = er + einc1;
      end
      else
      begin
        ad = ad + {{16{inc2[15]}}, inc2};
        er = er - einc2;
      end
    end
  endtask : expect_seg

  always @(posedge core_clk) pixReady <= ($urandom_range(0, 3) != 0);

  // source feeder: offer the next queued dword once the current one is taken
  always @(posedge core_clk)
  begin
    if (srcValid !== 1'b1 || srcReady === 1'b1)
    begin
      srcValid <= (srcq.size() != 0);
      if (srcq.size() != 0)
        {srcLast, srcData} <= srcq.pop_front();
    end
  end

  always @(posedge core_clk)
  begin
    logic [74:0] e;
    cyc++;
    if (cyc == 20000)
    begin
      fail("timeout");
      tally_and_finish();
    end
    else if (!rst && pixValid === 1'b1 && pixReady === 1'b1)
    begin
      n_checks++;
      if (expq.size() == 0) fail("extra pixel");
      else
      begin
        e = expq.pop_front();
        if ({pixAddr, pixData, pixRop, pixBitmap, pixByteMask} !== e)
          fail("pixel address, colour or attributes");
      end
    end
  end

  initial
  begin
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] r;
    logic        pk;
    logic [63:0] sv;
    int          j;
    void'($urandom(18));
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    axi_write(HREG_ADDR, 32'h1234_5678);
    axi_read(HREG_ADDR, r);
    n_checks++;
    if (r !== 32'h1234_5678) fail("address register readback");
    for (int k = 0; k < 6; k++)
    begin
      pk = k[0];
      inc1 = (16'($urandom_range(0, 15)) - 16'h0008) << (pk ? 0 : 2);
      inc2 = (16'($urandom_range(0, 15)) - 16'h0008) << (pk ? 0 : 2);
      einc1 = 16'($urandom_range(0, 20));
      einc2 = 16'($urandom_range(0, 20));
      ierr = 16'($urandom_range(0, 40)) - 16'h0014;
      len = (k < 2) ? 4'(k) : 4'($urandom_range(2, 15));
      fg = $urandom;
      bg = $urandom;
      rop = $urandom;
      send(1'b0, REG_STEP_ONE, {inc1, einc1});
      send(1'b0, REG_STEP_TWO, {inc2, einc2});
      send(1'b0, REG_INIT_LEN, {ierr, 12'h000, len});
      send(1'b0, REG_ROP, rop);
      send(1'b0, REG_FG, fg);
      send(1'b0, REG_BG, bg);
      send(1'b0, REG_MODE, pk ? 32'h0000_0011 : 32'h0000_0001);
      for (int s = 0; s < 2; s++)
      begin
        a = $urandom & 32'h000F_FFFF;
        d = $urandom;
        expect_seg(a, d, pk);
        send(1'b1, a, d);
      end
      do @(posedge core_clk); while (busy !== 1'b0);
      n_checks++;
      if (expq.size() != 0) fail("pixels missing");
    end
    // scaled copy: packed unity reduce, start 1, end 2, two trailing copies
    send(1'b0, REG_INTERLOCK, 32'h0000_0000);
    send(1'b0, REG_STEP_TWO, 32'h0000_0000);
    send(1'b0, REG_INIT_LEN, 32'h0000_0000);
    send(1'b0, REG_SPAN_CTL, 32'h0000_0221);
    send(1'b0, REG_MODE, 32'h0000_0032);
    a = $urandom & 32'h000F_FFFF;
    sv = {$urandom, $urandom};
    srcq.push_back({1'b0, sv[31:0]});
    srcq.push_back({1'b1, sv[63:32]});
    for (int i = 0; i < 7; i++)
    begin
      j = (i < 6) ? i + 1 : 6;
      expq.push_back({a + 32'(i), 24'h0, sv[8*j +: 8], rop[3:0], rop[10:8], rop[19:16]});
    end
    send(1'b1, a, 32'h0000_0000);
    send(1'b0, REG_INTERLOCK, 32'h0000_0000);
    send(1'b0, REG_STEP_ONE, 32'h0000_0000);
    n_checks++;
    if (expq.size() > 1) fail("interlocked write taken during copy");
    do @(posedge core_clk); while (busy !== 1'b0);
    n_checks++;
    if (expq.size() != 0) fail("copy pixels missing");
    // start beyond end on a one-dword span ends without output
    send(1'b0, REG_SPAN_CTL, 32'h0000_0013);
    srcq.push_back({1'b1, sv[31:0]});
    send(1'b1, a, 32'h0000_0000);
    do @(posedge core_clk); while (busy !== 1'b0);
    n_checks++;
    if (expq.size() != 0 || srcValid !== 1'b0) fail("bad span left work");
    axi_read(HREG_STATUS, r);
    n_checks++;
    if (r[15:8] !== 8'h40 || r[HST_OVERRUN] !== 1'b0) fail("status count or overrun");
    tally_and_finish();
  end
endmodule : bresenham_line_and_span_engine_bench
`default_nettype wire
